// file: tfp_pkg.sv
// package for the timer event flags and shared prescaler block
// assumes a single 100 MHz core clock and a 32-bit Avalon-MM register bus
package tfp_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] TFP_IDX_EVENT_FLAGS = 8'h39;
	localparam logic [7:0] TFP_IDX_TIMER_SETUP = 8'h3c;
	localparam logic [7:0] TFP_IDX_GENERAL_CTRL = 8'h43;
	localparam int TFP_ADDR_W = 10;

	// timer_event_flags bit positions
	localparam int TFP_BIT_OVERFLOW = 7;
	localparam int TFP_BIT_COMPARE_B = 6;
	localparam int TFP_BIT_COMPARE_A = 5;
	localparam int TFP_BIT_CAPTURE = 3;

	// general_timer_control bit positions
	localparam int TFP_BIT_SYNC_HOLD = 7;
	localparam int TFP_BIT_PSC_RESET = 0;

	// timer_setup field positions
	localparam int TFP_POS_T1_CS = 0;
	localparam int TFP_POS_T0_CS = 4;
	localparam int TFP_POS_WAVE = 8;
	localparam int TFP_BIT_CAP_IRQ_EN = 12;

	// reset values
	localparam logic [7:0] TFP_RST_FLAGS = 8'h00;
	localparam logic [2:0] TFP_RST_CS = 3'h0;
	localparam logic [3:0] TFP_RST_WAVE = 4'h0;

	// prescaler
	localparam int TFP_PSC_W = 10;
	localparam int TFP_SYNC_STAGES = 3;

	// waveform modes that matter to the flags
	localparam logic [3:0] TFP_WAVE_NORMAL = 4'h0;
	localparam logic [3:0] TFP_WAVE_CTC_A = 4'h4;
	localparam logic [3:0] TFP_WAVE_CTC_CAP = 4'hc;

	// clock source select codes
	typedef enum logic [2:0] {
		TFP_CS_STOP = 3'b000,
		TFP_CS_DIV1 = 3'b001,
		TFP_CS_DIV8 = 3'b010,
		TFP_CS_DIV64 = 3'b011,
		TFP_CS_DIV256 = 3'b100,
		TFP_CS_DIV1024 = 3'b101,
		TFP_CS_PIN_FALL = 3'b110,
		TFP_CS_PIN_RISE = 3'b111
	} tfp_cs_e;

	// events reported by the counter core of timer 1
	typedef struct packed {
		logic match_a;
		logic match_b;
		logic overflow;
		logic at_top;
		logic capture_event;
		logic force_a;
		logic force_b;
	} tfp_core_ev_s;

	// interrupt vector execution acknowledges
	typedef struct packed {
		logic overflow;
		logic compare_a;
		logic compare_b;
		logic capture;
	} tfp_vec_ack_s;

	// whole state of the block
	typedef struct packed {
		logic wait_n;
		logic [31:0] rdata;
		logic overflow_flag;
		logic compare_b_flag;
		logic compare_a_flag;
		logic capture_flag;
		logic [2:0] t1_cs;
		logic [2:0] t0_cs;
		logic [3:0] wave;
		logic capture_irq_enable;
		logic sync_hold_mode;
		logic prescaler_reset_bit;
		logic [TFP_PSC_W-1:0] psc;
		logic [TFP_SYNC_STAGES-1:0] t0_sync;
		logic [TFP_SYNC_STAGES-1:0] t1_sync;
		logic t0_tick;
		logic t1_tick;
		logic capture_irq;
	} tfp_state_s;
endpackage

// file: tfp_top.sv
// timer event flags, capture interrupt request, shared prescaler and count pin edge logic
// assumes the timer 1 counter core supplies match, overflow, top and capture events
// sampled on its tick, and an Avalon-MM master on the same clock
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns

// Overview of operation
// - capture request high when capture enable, global enable and capture flag all set
// - overflow flag set on overflow in normal and ctc modes, else per mode
// - each flag cleared by its vector acknowledge or by writing one
// - compare b flag set on the tick ending the matching timer cycle
// - compare a flag set on the tick ending the matching timer cycle
// - forced compare strobes never set compare flags
// - reserved flag bit always reads zero
// - capture flag set by capture event, or instead by reaching top when capture is top
// - one prescaler, separate clock selects, taps 1, 8, 64, 256, 1024
// - prescaler free runs regardless of selection; first count after 1 to N+1
// - count pins sampled every clock through synchroniser into edge detector
// - synchroniser flops update on the rising clock edge
// - edge detector gives one tick per chosen rising or falling edge
// - pin edge to count tick takes about three clock cycles
// - pin clock feeds the counter without prescaler division
// - with sync hold mode set, prescaler reset bit keeps written value
// - writing sync hold mode zero clears prescaler reset bit, timers resume
// - writing one to prescaler reset bit resets prescaler, self clears unless held
// - clock select codes 0..7: stop, /1, /8, /64, /256, /1024, fall, rise
module tfp_top
	import tfp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [TFP_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_global_irq_enable,
	input wire tfp_core_ev_s i_core_ev,
	input wire tfp_vec_ack_s i_vec_ack,
	input wire logic i_t0_count_pin,
	input wire logic i_t1_count_pin,
	output logic o_t0_tick,
	output logic o_t1_tick,
	output logic o_capture_irq,
	output logic [3:0] o_wave_mode,
	output logic o_overflow_flag,
	output logic o_compare_a_flag,
	output logic o_compare_b_flag,
	output logic o_capture_flag
);

	tfp_state_s s_q;
	tfp_state_s s_d;

	// one tick for the chosen source; prescaled taps and the undivided clock share the
	// prescaler reset so a held reset halts both timers on internal sources; pin clocks keep ticking
	function automatic logic tick_sel(input logic [2:0] cs, input logic [TFP_PSC_W-1:0] psc,
		input logic hold, input logic [TFP_SYNC_STAGES-1:0] sync);
		logic rise;
		logic fall;
		rise = sync[1] & ~sync[2];
		fall = ~sync[1] & sync[2];
		case (tfp_cs_e'(cs))
			TFP_CS_STOP: tick_sel = 1'b0;
			TFP_CS_DIV1: tick_sel = ~hold;
			TFP_CS_DIV8: tick_sel = ~hold & (psc[2:0] == 3'h7);
			TFP_CS_DIV64: tick_sel = ~hold & (psc[5:0] == 6'h3f);
			TFP_CS_DIV256: tick_sel = ~hold & (psc[7:0] == 8'hff);
			TFP_CS_DIV1024: tick_sel = ~hold & (psc == 10'h3ff);
			TFP_CS_PIN_FALL: tick_sel = fall;
			TFP_CS_PIN_RISE: tick_sel = rise;
			default: tick_sel = 1'b0;
		endcase
	endfunction

	// modes in which the capture register sets top
	function automatic logic capture_is_top(input logic [3:0] wave);
		capture_is_top = (wave == TFP_WAVE_CTC_CAP) || (wave == 4'h8) ||
			(wave == 4'ha) || (wave == 4'he);
	endfunction

	logic sel_flags;
	logic sel_setup;
	logic sel_general;
	logic bus_req;
	logic wr_fire;
	logic [7:0] flags_view;
	logic [7:0] general_view;
	logic [15:0] setup_view;
	logic ovf_set;
	logic cap_set;
	logic cmp_a_set;
	logic cmp_b_set;

	// address decode on word index; byte address bits [1:0] are ignored
	assign sel_flags = (i_avs_address[TFP_ADDR_W-1:2] == TFP_IDX_EVENT_FLAGS);
	assign sel_setup = (i_avs_address[TFP_ADDR_W-1:2] == TFP_IDX_TIMER_SETUP);
	assign sel_general = (i_avs_address[TFP_ADDR_W-1:2] == TFP_IDX_GENERAL_CTRL);
	assign bus_req = i_avs_read | i_avs_write;
	// a write lands only in the cycle where waitrequest is low
	assign wr_fire = i_avs_write & s_q.wait_n;

	// register views; bit 4 and the timer 0 flag bits read as zero
	always_comb begin
		flags_view = TFP_RST_FLAGS;
		flags_view[TFP_BIT_OVERFLOW] = s_q.overflow_flag;
		flags_view[TFP_BIT_COMPARE_B] = s_q.compare_b_flag;
		flags_view[TFP_BIT_COMPARE_A] = s_q.compare_a_flag;
		flags_view[TFP_BIT_CAPTURE] = s_q.capture_flag;
		general_view = 8'h00;
		general_view[TFP_BIT_SYNC_HOLD] = s_q.sync_hold_mode;
		general_view[TFP_BIT_PSC_RESET] = s_q.prescaler_reset_bit;
		setup_view = 16'h0000;
		setup_view[TFP_POS_T1_CS +: 3] = s_q.t1_cs;
		setup_view[TFP_POS_T0_CS +: 3] = s_q.t0_cs;
		setup_view[TFP_POS_WAVE +: 4] = s_q.wave;
		setup_view[TFP_BIT_CAP_IRQ_EN] = s_q.capture_irq_enable;
	end

	// flag set terms, all but the capture event term qualified by the timer 1 tick that closes the matching cycle;
	// force strobes are not looked at, so they can never set a compare flag
	always_comb begin
		cmp_a_set = s_q.t1_tick & i_core_ev.match_a;
		cmp_b_set = s_q.t1_tick & i_core_ev.match_b;
		if (s_q.wave == TFP_WAVE_NORMAL || s_q.wave == TFP_WAVE_CTC_A ||
			s_q.wave == TFP_WAVE_CTC_CAP) begin
			ovf_set = s_q.t1_tick & i_core_ev.overflow;
		end else begin
			ovf_set = s_q.t1_tick & i_core_ev.at_top;
		end
		if (capture_is_top(s_q.wave)) begin
			cap_set = s_q.t1_tick & i_core_ev.at_top;
		end else begin
			cap_set = i_core_ev.capture_event;
		end
	end

	// next state
	always_comb begin
		s_d = s_q;

		// bus handshake: one wait cycle, then one cycle with waitrequest low
		s_d.wait_n = bus_req & ~s_q.wait_n;
		s_d.rdata = 32'h0000_0000;
		if (i_avs_read & ~s_q.wait_n) begin
			if (sel_flags) begin
				s_d.rdata = {24'h00_0000, flags_view};
			end else if (sel_setup) begin
				s_d.rdata = {16'h0000, setup_view};
			end else if (sel_general) begin
				s_d.rdata = {24'h00_0000, general_view};
			end
		end

		// flags: clear by vector or write-one, a same-cycle set wins
		if (i_vec_ack.overflow || (wr_fire && sel_flags && i_avs_byteenable[0] &&
			i_avs_writedata[TFP_BIT_OVERFLOW])) begin
			s_d.overflow_flag = 1'b0;
		end
		if (i_vec_ack.compare_b || (wr_fire && sel_flags && i_avs_byteenable[0] &&
			i_avs_writedata[TFP_BIT_COMPARE_B])) begin
			s_d.compare_b_flag = 1'b0;
		end
		if (i_vec_ack.compare_a || (wr_fire && sel_flags && i_avs_byteenable[0] &&
			i_avs_writedata[TFP_BIT_COMPARE_A])) begin
			s_d.compare_a_flag = 1'b0;
		end
		if (i_vec_ack.capture || (wr_fire && sel_flags && i_avs_byteenable[0] &&
			i_avs_writedata[TFP_BIT_CAPTURE])) begin
			s_d.capture_flag = 1'b0;
		end
		if (ovf_set) begin
			s_d.overflow_flag = 1'b1;
		end
		if (cmp_b_set) begin
			s_d.compare_b_flag = 1'b1;
		end
		if (cmp_a_set) begin
			s_d.compare_a_flag = 1'b1;
		end
		if (cap_set) begin
			s_d.capture_flag = 1'b1;
		end

		// setup register, per byte lane
		if (wr_fire && sel_setup && i_avs_byteenable[0]) begin
			s_d.t1_cs = i_avs_writedata[TFP_POS_T1_CS +: 3];
			s_d.t0_cs = i_avs_writedata[TFP_POS_T0_CS +: 3];
		end
		if (wr_fire && sel_setup && i_avs_byteenable[1]) begin
			s_d.wave = i_avs_writedata[TFP_POS_WAVE +: 4];
			s_d.capture_irq_enable = i_avs_writedata[TFP_BIT_CAP_IRQ_EN];
		end

		// prescaler reset bit self clears unless sync hold mode keeps it
		if (!s_q.sync_hold_mode) begin
			s_d.prescaler_reset_bit = 1'b0;
		end
		if (wr_fire && sel_general && i_avs_byteenable[0]) begin
			s_d.sync_hold_mode = i_avs_writedata[TFP_BIT_SYNC_HOLD];
			if (i_avs_writedata[TFP_BIT_SYNC_HOLD]) begin
				s_d.prescaler_reset_bit = i_avs_writedata[TFP_BIT_PSC_RESET];
			end else begin
				// leaving hold mode drops the reset so timers restart
				s_d.prescaler_reset_bit = 1'b0;
			end
		end

		// free-running prescaler, zeroed for every cycle a one sits in the reset bit
		// and on the write of a one even outside hold mode
		if (s_q.prescaler_reset_bit || (wr_fire && sel_general && i_avs_byteenable[0] &&
			i_avs_writedata[TFP_BIT_PSC_RESET])) begin
			s_d.psc = '0;
		end else begin
			s_d.psc = s_q.psc + 10'h001;
		end

		// three-stage pin synchronisers; stage 0 only feeds stage 1
		s_d.t0_sync = {s_q.t0_sync[1:0], i_t0_count_pin};
		s_d.t1_sync = {s_q.t1_sync[1:0], i_t1_count_pin};

		// registered ticks; a pin edge reaches the tick three edges later
		s_d.t0_tick = tick_sel(s_q.t0_cs, s_q.psc, s_q.prescaler_reset_bit,
			s_q.t0_sync);
		s_d.t1_tick = tick_sel(s_q.t1_cs, s_q.psc, s_q.prescaler_reset_bit,
			s_q.t1_sync);

		// capture request follows the flag one cycle later
		s_d.capture_irq = s_q.capture_irq_enable & i_global_irq_enable &
			s_q.capture_flag;
	end

	// state register with synchronous reset
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			s_q.wait_n <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
			s_q.overflow_flag <= TFP_RST_FLAGS[TFP_BIT_OVERFLOW];
			s_q.compare_b_flag <= TFP_RST_FLAGS[TFP_BIT_COMPARE_B];
			s_q.compare_a_flag <= TFP_RST_FLAGS[TFP_BIT_COMPARE_A];
			s_q.capture_flag <= TFP_RST_FLAGS[TFP_BIT_CAPTURE];
			s_q.t1_cs <= TFP_RST_CS;
			s_q.t0_cs <= TFP_RST_CS;
			s_q.wave <= TFP_RST_WAVE;
			s_q.capture_irq_enable <= 1'b0;
			s_q.sync_hold_mode <= 1'b0;
			s_q.prescaler_reset_bit <= 1'b0;
			s_q.psc <= '0;
			s_q.t0_sync <= '0;
			s_q.t1_sync <= '0;
			s_q.t0_tick <= 1'b0;
			s_q.t1_tick <= 1'b0;
			s_q.capture_irq <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flops
	assign o_avs_readdata = s_q.rdata;
	assign o_avs_waitrequest = ~s_q.wait_n;
	assign o_t0_tick = s_q.t0_tick;
	assign o_t1_tick = s_q.t1_tick;
	assign o_capture_irq = s_q.capture_irq;
	assign o_wave_mode = s_q.wave;
	assign o_overflow_flag = s_q.overflow_flag;
	assign o_compare_a_flag = s_q.compare_a_flag;
	assign o_compare_b_flag = s_q.compare_b_flag;
	assign o_capture_flag = s_q.capture_flag;

endmodule

// file: tfp_chk_asserts.sv
// checker for the timer flag and prescaler block
// assumes it sees only the top ports; bound to tfp_top at the foot
`timescale 1ns/1ns
module tfp_chk
	import tfp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [TFP_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_global_irq_enable,
	input wire tfp_core_ev_s i_core_ev,
	input wire tfp_vec_ack_s i_vec_ack,
	input wire logic o_t1_tick,
	input wire logic o_capture_irq,
	input wire logic [3:0] o_wave_mode,
	input wire logic o_overflow_flag,
	input wire logic o_compare_a_flag,
	input wire logic o_compare_b_flag,
	input wire logic o_capture_flag
);
	// one clock domain, so clock and disable are given once
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// request only follows the flag and the global enable
	property p_irq; o_capture_irq |-> $past(o_capture_flag && i_global_irq_enable); endproperty
	a_irq: assert property (p_irq) else $error("capture request without its terms");
	property p_wait; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("waitrequest low too long");
	property p_ovf; $rose(o_overflow_flag) |-> $past(o_t1_tick); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag set off a tick");
	property p_cmp_a; $rose(o_compare_a_flag) |-> $past(o_t1_tick && i_core_ev.match_a); endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("compare a flag without match");
	property p_cmp_b; o_t1_tick && i_core_ev.match_b |=> o_compare_b_flag; endproperty
	a_cmp_b: assert property (p_cmp_b) else $error("compare b flag not set");
	// a vector acknowledge with no set pending clears the flag
	property p_ack;
		i_vec_ack.overflow && !(o_t1_tick && (i_core_ev.overflow || i_core_ev.at_top))
			|=> !o_overflow_flag;
	endproperty
	a_ack: assert property (p_ack) else $error("overflow flag kept after ack");
	property p_resv;
		!o_avs_waitrequest && i_avs_read && i_avs_address[9:2] == TFP_IDX_EVENT_FLAGS
			|-> o_avs_readdata[4] == 1'b0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved flag bit read as one");
	property p_cap;
		i_core_ev.capture_event && !(o_wave_mode[3] && !o_wave_mode[0]) |=> o_capture_flag;
	endproperty
	a_cap: assert property (p_cap) else $error("capture flag not set");
	c_irq: cover property (o_capture_irq);
	c_tick: cover property (o_t1_tick);
	c_cmp: cover property ($rose(o_compare_a_flag));
endmodule

bind tfp_top tfp_chk chk (.i_core_clk, .i_reset_n, .i_avs_address, .i_avs_read,
	.o_avs_readdata, .o_avs_waitrequest, .i_global_irq_enable, .i_core_ev, .i_vec_ack,
	.o_t1_tick, .o_capture_irq, .o_wave_mode, .o_overflow_flag, .o_compare_a_flag,
	.o_compare_b_flag, .o_capture_flag);

// file: tfp_pin_src.sv
// external clock source for the count pin
// assumes the bench starts and stops it only while the pin is steady
`timescale 1ns/1ns
module tfp_pin_src #(
	parameter int HALF = 3
) (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_pin,
	output int o_rises,
	output int o_falls
);
	int cnt;
	initial begin
		o_pin = 1'b0;
		o_rises = 0;
		o_falls = 0;
		cnt = 0;
	end
	// each half period spans HALF core cycles; the pin stands still when stopped
	always @(posedge i_clk) begin
		if (i_run) begin
			if (cnt == HALF - 1) begin
				cnt <= 0;
				o_pin <= !o_pin;
				if (o_pin) o_falls <= o_falls + 1;
				else o_rises <= o_rises + 1;
			end else cnt <= cnt + 1;
		end
	end
endmodule

// file: tfp_top_bench.sv
// self-checking bench for the timer flag and prescaler block
// assumes the checker is bound by its own file and the pin source drives both count pins
`timescale 1ns/1ns
module tfp_top_bench;
	import tfp_pkg::*;
	localparam logic [9:0] A_FLG = 10'h0e4, A_SET = 10'h0f0, A_GEN = 10'h10c;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, gie = 0, run = 0;
	logic [9:0] adr = '0;
	logic [31:0] wd = '0, q, rdata;
	logic [3:0] be = 4'hf, wave;
	logic wreq, t0t, t1t, irq, ovf, cfa, cfb, cap;
	tfp_core_ev_s ev = '0;
	tfp_vec_ack_s ack = '0;
	int failures = 0, n_compared = 0, rises, falls, c, c2, c0, r0, f0;
	wire pin;
	always #5 clk = !clk;
	tfp_top uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_global_irq_enable(gie), .i_core_ev(ev), .i_vec_ack(ack),
		.i_t0_count_pin(pin), .i_t1_count_pin(pin), .o_t0_tick(t0t), .o_t1_tick(t1t),
		.o_capture_irq(irq), .o_wave_mode(wave), .o_overflow_flag(ovf),
		.o_compare_a_flag(cfa), .o_compare_b_flag(cfb), .o_capture_flag(cap));
	tfp_pin_src src (.i_clk(clk), .i_run(run), .o_pin(pin), .o_rises(rises), .o_falls(falls));
	task conclude;
		if (failures == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus transfer; the request stands until waitrequest is sampled low
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
		if (n >= 50) begin
			failures++;
			conclude();
		end
	endtask
	task ev_p(input tfp_core_ev_s e);
		ev <= e;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask
	task count(input int n);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			if (t1t === 1'b1) c++;
			if (t0t === 1'b1) c0++;
		end
	endtask
	task s_reset;
		bus(0, A_FLG, 0);
		chk("flags", q, 0);
		bus(0, A_SET, 0);
		chk("setup", q, 0);
		bus(1, 10'h000, 32'hffffffff);
		bus(0, 10'h000, 0);
		chk("unmapped", q, 0);
	endtask
	task s_flags;
		bus(1, A_SET, 32'h1);
		ev_p(7'b1110000);
		chk("set", {ovf, cfb, cfa}, 3'b111);
		bus(0, A_FLG, 0);
		chk("flag read", q, 32'he0);
		bus(1, A_FLG, 32'h80);
		chk("write one", ovf, 0);
		ack <= 4'b1110;
		@(posedge clk);
		ack <= '0;
		@(posedge clk);
		chk("vector ack", {cfa, cfb}, 0);
		ev_p(7'b0000011);
		chk("forced", {cfa, cfb}, 0);
	endtask
	// capture flag from the core capture event and from top, request gated by global enable
	task s_capture;
		bus(1, A_SET, 32'h1001);
		gie <= 1'b1;
		ev_p(7'b0000100);
		chk("capture", cap, 1);
		@(posedge clk);
		chk("irq on", irq, 1);
		gie <= 1'b0;
		repeat (2) @(posedge clk);
		chk("irq off", irq, 0);
		bus(1, A_FLG, 32'h08);
		bus(1, A_SET, 32'h0c01);
		chk("wave mode", wave, 4'hc);
		ev_p(7'b0000100);
		chk("capture as top", cap, 0);
		ev_p(7'b0001000);
		chk("top reached", cap, 1);
	endtask
	task s_psc;
		int dv[6] = '{8, 1, 8, 64, 256, 1024};
		for (int k = 0; k < 6; k++) begin
			bus(1, A_SET, k);
			count(2 * dv[k]);
			chk("tap ticks", c, k ? 2 : 0);
		end
		bus(1, A_SET, 2);
		bus(1, A_GEN, 32'h81);
		count(40);
		chk("held", c, 0);
		bus(0, A_GEN, 0);
		chk("held bit", q, 32'h81);
		bus(1, A_GEN, 0);
		c2 = 0;
		while (t1t !== 1'b1 && c2 < 20) begin
			@(posedge clk);
			c2++;
		end
		chk("first count", c2 <= 9, 1);
		if (c2 >= 20) conclude();
		count(80);
		chk("resumed", c, 10);
		bus(1, A_GEN, 1);
		bus(0, A_GEN, 0);
		chk("self clear", q, 0);
	endtask
	// pin clocking switched only while the source stands still
	task s_pin;
		for (int cs = 6; cs < 8; cs++) begin
			bus(1, A_SET, cs | (cs << 4));
			r0 = rises;
			f0 = falls;
			c0 = 0;
			run <= 1'b1;
			count(60);
			c2 = c;
			run <= 1'b0;
			count(10);
			chk("pin ticks", c + c2, cs == 7 ? rises - r0 : falls - f0);
			chk("t0 pin ticks", c0, cs == 7 ? rises - r0 : falls - f0);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		s_reset();
		s_flags();
		s_capture();
		s_psc();
		s_pin();
		conclude();
	end
endmodule
